// ---- core/clk_stop_cfg.svh ----
`ifndef CLK_STOP_CFG_SVH
`define CLK_STOP_CFG_SVH

// Byte addresses on the configuration port
`define CSP_ADDR_SPREAD 8'h01
`define CSP_ADDR_OE 8'h02
`define CSP_ADDR_HALT_CTRL 8'h0A
`define CSP_ADDR_PART_ID 8'h0E

// Field positions
`define CSP_SPREAD_LSB 1
`define CSP_SPREAD_MSB 4
`define CSP_HALT_LSB 0
`define CSP_HALT_MSB 1
`define CSP_OE_LSB 0
`define CSP_OE_MSB 5
`define CSP_OE_CPU0 0
`define CSP_OE_AUX 2
`define CSP_OE_REF 3
`define CSP_OE_VNSS 4
`define CSP_OE_VSS 5

// Reset values
`define CSP_SPREAD_RST 4'h0
`define CSP_HALT_RST 2'h3
`define CSP_OE_RST 6'h3F
`define CSP_ID_RSVD 3'h5

// Valid spread selection range
`define CSP_CODE_MIN 4'h2
`define CSP_CODE_MAX 4'hA

// Timing
`define CSP_CLK_MHZ 25
`define CSP_LOCK_US 1800
`define CSP_PD_EDGES 2'h2
`define CSP_HALT_EDGES 2'h2
`define CSP_DRAIN_CYC 3'h4

`endif

// ---- core/clk_stop_pkg.sv ----
package clk_stop_pkg;

	typedef enum logic [2:0] {
		ST_WAIT_GOOD,
		ST_STARTUP,
		ST_RUN,
		ST_DRAIN,
		ST_OFF
	} power_state_type;

	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cfg_req_type;

	typedef struct packed {
		logic clk_true;
		logic clk_comp;
	} diff_pair_type;

endpackage

// ---- core/clock_output_stop_powerdown.sv ----
// Behaviour
// R1: Byte 14 bits 4..0 read the programmed part identification; bits 7..5 reserved.
// R2: Spread code in byte 1 bits 4..1; codes 2..10 enable both video clocks.
// R3: A halted CPU pair parks with true leg high, complement low.
// R4: Power-down: single-ended low, or released with strap; differential legs both low.
// R5: Shared pin acts as supply-good until seen high, then as power-down.
// R6: Power-down entry is synchronised; release is taken immediately to restart.
// R7: Clocks are driven low and held before oscillator and VCO turn off.
// R8: Two low samples on CPU rising edges stop outputs at next falling edge.
// R9: Controller asserts power-down within 10 us of supply-good for initial power-down.
// R10: Stable clocks within 1.8 ms of power-down release or supply ramp.
// R11: Differential outputs are pulled high soon after power-down release.
// R12: After lock, every output starts within a few of its cycles.
// R13: Active-low CPU halt stops and restarts CPU clocks; others keep running.
// R14: Only CPU outputs marked haltable respond; free ones and single-ended keep running.
// R15: Halt seen on two complement rising edges stops outputs in two to six periods.
// R16: Release resumes halted outputs in step, without short or stretched pulses.
// R17: Halted outputs resume within two CPU cycles of release.
// R18: Per-CPU haltable bits in byte 10, both reset to haltable.
// R19: Output disabled by its enable bit drives low, both differential legs low.
// R20: Power-down input passes a two-stage synchroniser before reaching the gating.
`include "clk_stop_cfg.svh"

module clock_output_stop_powerdown
	import clk_stop_pkg::*;
#(
	parameter int LOCK_CYC = `CSP_LOCK_US * `CSP_CLK_MHZ,
	parameter logic [4:0] PART_ID = 5'h00
) (
	input logic core_clk,
	input logic rst,
	input logic power_down_n,
	input logic cpu_halt_n,
	input logic se_hiz_strap,
	input cfg_req_type cfg_req,
	output logic [7:0] cfg_rdata,
	output logic [1:0] cpu_clk_true,
	output logic [1:0] cpu_clk_comp,
	output diff_pair_type aux_diff,
	output logic ref_clk,
	output logic ref_clk_oe,
	output logic video_clk_nonspread,
	output logic video_clk_nonspread_oe,
	output logic video_clk_spread,
	output logic video_clk_spread_oe,
	output logic [3:0] spread_code,
	output logic pll_enable,
	output logic xtal_enable
);
	localparam int CW = $clog2(LOCK_CYC + 1);

	power_state_type state_q;
	logic [3:0] spread_code_q;
	logic [5:0] oe_q;
	logic [1:0] haltable_q;
	logic [7:0] cfg_rdata_q;
	logic clk_phase_q;
	logic pd_sync;
	logic [1:0] pd_cnt_q;
	logic pd_req;
	logic [CW-1:0] lock_cnt_q;
	logic [2:0] drain_cnt_q;
	logic [1:0] stopped;
	logic [1:0] cpu_true_q;
	logic [1:0] cpu_comp_q;
	diff_pair_type aux_q;
	logic [2:0] se_q;
	logic [2:0] se_oe_q;
	logic [2:0] se_en;
	logic pll_q;
	logic xtal_q;
	logic supply_good_in;
	logic running;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	function automatic logic spread_valid(input logic [3:0] code);
		spread_valid = (code >= `CSP_CODE_MIN) && (code <= `CSP_CODE_MAX);
	endfunction

	function automatic logic [7:0] reg_read(input logic [7:0] addr);
		case (addr)
			`CSP_ADDR_SPREAD: reg_read = 8'(spread_code_q) << `CSP_SPREAD_LSB;
			`CSP_ADDR_OE: reg_read = 8'(oe_q) << `CSP_OE_LSB;
			`CSP_ADDR_HALT_CTRL: reg_read = 8'(haltable_q) << `CSP_HALT_LSB;
			`CSP_ADDR_PART_ID: reg_read = {`CSP_ID_RSVD, PART_ID}; // see R1
			default: reg_read = 8'h00;
		endcase
	endfunction

	// Shared pin: supply-good before first high sample
	assign supply_good_in = power_down_n;
	assign running = (state_q == ST_RUN);

	// Configuration writes
	always_ff @(posedge core_clk) begin
		if (rst) begin
			spread_code_q <= `CSP_SPREAD_RST;
			oe_q <= `CSP_OE_RST;
			haltable_q <= `CSP_HALT_RST; // see R18
		end else if (cfg_req.wr) begin
			case (cfg_req.addr)
				`CSP_ADDR_SPREAD: spread_code_q <= cfg_req.wdata[`CSP_SPREAD_MSB:`CSP_SPREAD_LSB]; // see R2
				`CSP_ADDR_OE: oe_q <= cfg_req.wdata[`CSP_OE_MSB:`CSP_OE_LSB];
				`CSP_ADDR_HALT_CTRL: haltable_q <= cfg_req.wdata[`CSP_HALT_MSB:`CSP_HALT_LSB]; // see R18
				default: ;
			endcase
		end
	end

	// Registered read data
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cfg_rdata_q <= 8'h00;
		end else begin
			cfg_rdata_q <= reg_read(cfg_req.addr);
		end
	end

	property p_part_id;
		cfg_req.addr == `CSP_ADDR_PART_ID |=> cfg_rdata_q == {`CSP_ID_RSVD, PART_ID};
	endproperty
	a_part_id: assert property (p_part_id) else $error("part id read wrong"); // see R1

	// Internal CPU clock reference
	always_ff @(posedge core_clk) begin
		if (rst) begin
			clk_phase_q <= 1'b0;
		end else begin
			clk_phase_q <= ~clk_phase_q;
		end
	end

	sync2 #(.RST_VAL(1'b1)) u_pd_sync (
		.core_clk(core_clk),
		.rst(rst),
		.din(power_down_n),
		.dout(pd_sync)
	); // see R20

	// Count CPU rising edges with power-down low
	always_ff @(posedge core_clk) begin
		if (rst || pd_sync || power_down_n) begin
			pd_cnt_q <= 2'h0;
		end else if (!clk_phase_q && pd_cnt_q != `CSP_PD_EDGES) begin // see R8
			pd_cnt_q <= pd_cnt_q + 2'h1;
		end
	end

	assign pd_req = (pd_cnt_q == `CSP_PD_EDGES) && !pd_sync; // see R6

	// Power state sequence
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_q <= ST_WAIT_GOOD;
		end else begin
			case (state_q)
				ST_WAIT_GOOD: begin
					if (supply_good_in) begin // see R5
						state_q <= ST_STARTUP;
					end
				end
				ST_STARTUP: begin
					if (pd_req) begin
						state_q <= ST_DRAIN;
					end else if (lock_cnt_q == CW'(LOCK_CYC - 1)) begin // see R10
						state_q <= ST_RUN; // see R12
					end
				end
				ST_RUN: begin
					if (pd_req) begin // see R8
						state_q <= ST_DRAIN;
					end
				end
				ST_DRAIN: begin
					if (drain_cnt_q == `CSP_DRAIN_CYC - 3'h1) begin // see R7
						state_q <= ST_OFF;
					end
				end
				ST_OFF: begin
					if (power_down_n) begin // see R6
						state_q <= ST_STARTUP;
					end
				end
				default: state_q <= ST_WAIT_GOOD;
			endcase
		end
	end

	// Lock wait
	always_ff @(posedge core_clk) begin
		if (rst || state_q != ST_STARTUP) begin
			lock_cnt_q <= '0;
		end else begin
			lock_cnt_q <= lock_cnt_q + CW'(1); // see R10
		end
	end

	// Hold clocks low before oscillators stop
	always_ff @(posedge core_clk) begin
		if (rst || state_q != ST_DRAIN) begin
			drain_cnt_q <= 3'h0;
		end else begin
			drain_cnt_q <= drain_cnt_q + 3'h1; // see R7
		end
	end

	// Oscillator and VCO enables
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pll_q <= 1'b0;
			xtal_q <= 1'b0;
		end else begin
			pll_q <= (state_q == ST_STARTUP) || running || (state_q == ST_DRAIN); // see R7
			xtal_q <= (state_q == ST_STARTUP) || running || (state_q == ST_DRAIN);
		end
	end

	cpu_halt_gate #(.N(2)) u_halt (
		.core_clk(core_clk),
		.rst(rst),
		.cpu_halt_n(cpu_halt_n),
		.clk_phase(clk_phase_q),
		.run(running),
		.haltable(haltable_q),
		.stopped(stopped)
	); // see R13

	// CPU differential pairs
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cpu_true_q <= 2'h0;
			cpu_comp_q <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				case (state_q)
					ST_RUN: begin
						if (oe_q[`CSP_OE_CPU0 + i]) begin
							cpu_true_q[i] <= stopped[i] | ~clk_phase_q; // see R3
							cpu_comp_q[i] <= ~(stopped[i] | ~clk_phase_q); // see R16
						end else begin
							cpu_true_q[i] <= 1'b0; // see R19
							cpu_comp_q[i] <= 1'b0;
						end
					end
					ST_STARTUP: begin
						cpu_true_q[i] <= 1'b1; // see R11
						cpu_comp_q[i] <= 1'b1;
					end
					default: begin
						cpu_true_q[i] <= 1'b0; // see R4
						cpu_comp_q[i] <= 1'b0;
					end
				endcase
			end
		end
	end

	// Non-CPU differential pair, never halted
	always_ff @(posedge core_clk) begin
		if (rst) begin
			aux_q <= '0;
		end else begin
			case (state_q)
				ST_RUN: begin
					aux_q.clk_true <= oe_q[`CSP_OE_AUX] & ~clk_phase_q; // see R14
					aux_q.clk_comp <= oe_q[`CSP_OE_AUX] & clk_phase_q; // see R19
				end
				ST_STARTUP: aux_q <= '1; // see R11
				default: aux_q <= '0; // see R4
			endcase
		end
	end

	assign se_en = {oe_q[`CSP_OE_VSS] & spread_valid(spread_code_q),
		oe_q[`CSP_OE_VNSS] & spread_valid(spread_code_q), oe_q[`CSP_OE_REF]}; // see R2

	// Single-ended outputs
	always_ff @(posedge core_clk) begin
		if (rst) begin
			se_q <= 3'h0;
			se_oe_q <= 3'h7;
		end else begin
			case (state_q)
				ST_RUN: begin
					se_q <= se_en & ~se_q; // see R19
					se_oe_q <= 3'h7;
				end
				ST_DRAIN, ST_OFF: begin
					se_q <= 3'h0; // see R8
					se_oe_q <= {3{~se_hiz_strap}}; // see R4
				end
				default: begin
					se_q <= 3'h0;
					se_oe_q <= 3'h7;
				end
			endcase
		end
	end

	assign cfg_rdata = cfg_rdata_q;
	assign cpu_clk_true = cpu_true_q;
	assign cpu_clk_comp = cpu_comp_q;
	assign aux_diff = aux_q;
	assign ref_clk = se_q[0];
	assign video_clk_nonspread = se_q[1];
	assign video_clk_spread = se_q[2];
	assign ref_clk_oe = se_oe_q[0];
	assign video_clk_nonspread_oe = se_oe_q[1];
	assign video_clk_spread_oe = se_oe_q[2];
	assign spread_code = spread_code_q;
	assign pll_enable = pll_q;
	assign xtal_enable = xtal_q;

	property p_spread_off;
		running && !spread_valid(spread_code_q) ##1 running |-> !se_q[1] && !se_q[2];
	endproperty
	a_spread_off: assert property (p_spread_off) else $error("video clock on"); // see R2

	property p_park;
		running && $past(running) && stopped[0] && oe_q[`CSP_OE_CPU0] |=>
			!$past(running, 2) || (cpu_true_q[0] && !cpu_comp_q[0]);
	endproperty
	a_park: assert property (p_park) else $error("halted pair not parked"); // see R3

	property p_pd_se;
		state_q == ST_OFF && se_hiz_strap |=> !se_oe_q[0] && se_q == 3'h0;
	endproperty
	a_pd_se: assert property (p_pd_se) else $error("strap output not released"); // see R4

	property p_pd_diff;
		state_q == ST_OFF |=> cpu_true_q == 2'h0 && cpu_comp_q == 2'h0 && aux_q == '0;
	endproperty
	a_pd_diff: assert property (p_pd_diff) else $error("diff leg high in power-down"); // see R4

	property p_wait_good;
		state_q == ST_WAIT_GOOD && !supply_good_in |=> state_q == ST_WAIT_GOOD;
	endproperty
	a_wait_good: assert property (p_wait_good) else $error("left wait early"); // see R5

	property p_release;
		state_q == ST_OFF && power_down_n |=> state_q == ST_STARTUP;
	endproperty
	a_release: assert property (p_release) else $error("release not taken"); // see R6

	sequence s_drain_entry;
		state_q == ST_RUN ##1 state_q == ST_DRAIN;
	endsequence

	sequence s_drain_hold;
		(state_q == ST_DRAIN && pll_q) [*4] ##1 state_q == ST_OFF;
	endsequence

	property p_drain;
		s_drain_entry |-> s_drain_hold;
	endproperty
	a_drain: assert property (p_drain) else $error("oscillator off too early"); // see R7

	property p_drain_low;
		state_q == ST_DRAIN ##1 state_q == ST_DRAIN |-> se_q == 3'h0 && cpu_true_q == 2'h0;
	endproperty
	a_drain_low: assert property (p_drain_low) else $error("clock high in drain"); // see R8

	property p_pd_entry;
		running && pd_req |=> state_q == ST_DRAIN;
	endproperty
	a_pd_entry: assert property (p_pd_entry) else $error("power-down missed"); // see R8

	property p_lock;
		state_q == ST_STARTUP |-> lock_cnt_q < CW'(LOCK_CYC);
	endproperty
	a_lock: assert property (p_lock) else $error("lock wait overrun"); // see R10

	property p_bias;
		state_q == ST_STARTUP ##1 state_q == ST_STARTUP |-> cpu_true_q == 2'h3 && aux_q == '1;
	endproperty
	a_bias: assert property (p_bias) else $error("diff not pulled high"); // see R11
endmodule // clock_output_stop_powerdown

// ---- core/cpu_halt_gate.sv ----
`include "clk_stop_cfg.svh"

module cpu_halt_gate #(
	parameter int N = 2
) (
	input logic core_clk,
	input logic rst,
	input logic cpu_halt_n,
	input logic clk_phase,
	input logic run,
	input logic [N-1:0] haltable,
	output logic [N-1:0] stopped
);
	logic halt_sync;
	logic [1:0] edge_cnt_q;
	logic halt_req;

	sync2 #(.RST_VAL(1'b1)) u_halt_sync (
		.core_clk(core_clk),
		.rst(rst),
		.din(cpu_halt_n),
		.dout(halt_sync)
	);

	// Count rising edges of the complement clock while halt is low
	always_ff @(posedge core_clk) begin
		if (rst || halt_sync) begin
			edge_cnt_q <= 2'h0;
		end else if (clk_phase && edge_cnt_q != `CSP_HALT_EDGES) begin // see R15
			edge_cnt_q <= edge_cnt_q + 2'h1;
		end
	end

	assign halt_req = (edge_cnt_q == `CSP_HALT_EDGES) && !halt_sync; // see R15

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_out
			// Change only when the true leg is about to be high
			always_ff @(posedge core_clk) begin
				if (rst) begin
					stopped[i] <= 1'b0;
				end else if (!clk_phase) begin // see R16
					stopped[i] <= halt_req && haltable[i] && run; // see R14
				end
			end

			property p_halt_stop;
				@(posedge core_clk) disable iff (rst)
				$rose(halt_req) && run && haltable[i] ##1 run |-> ##[0:1] stopped[i];
			endproperty
			a_halt_stop: assert property (p_halt_stop) else $error("halt stop late"); // see R15

			property p_free_runs;
				@(posedge core_clk) disable iff (rst)
				!haltable[i] && !$past(haltable[i]) |-> !stopped[i];
			endproperty
			a_free_runs: assert property (p_free_runs) else $error("free output stopped"); // see R14
		end
	endgenerate

	sequence s_release;
		$rose(halt_sync);
	endsequence

	property p_resume;
		@(posedge core_clk) disable iff (rst)
		s_release |-> ##[1:2] (stopped == '0);
	endproperty
	a_resume: assert property (p_resume) else $error("resume late"); // see R17
endmodule // cpu_halt_gate

// ---- core/sync2.sv ----
module sync2 #(
	parameter bit RST_VAL = 1'b1
) (
	input logic core_clk,
	input logic rst,
	input logic din,
	output logic dout
);
	logic meta_q;

	// Two stages; only the second stage is read
	always_ff @(posedge core_clk) begin
		if (rst) begin
			meta_q <= RST_VAL;
			dout <= RST_VAL;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule // sync2

// ---- verif/platform_ctl.sv ----
module platform_ctl (
	input logic core_clk,
	input logic supply_on,
	input logic pd_req,
	input logic halt_req,
	output logic power_down_n,
	output logic cpu_halt_n
);
	timeunit 1ns;
	timeprecision 1ns;

	logic good_q;

	initial begin
		power_down_n = 1'b0;
		cpu_halt_n = 1'b1;
		good_q = 1'b0;
	end

	// Pin shows supply-good high first; a wanted power-down follows two cycles later
	always @(posedge core_clk) begin
		power_down_n <= supply_on & ~(pd_req & good_q);
		good_q <= good_q | power_down_n;
		cpu_halt_n <= ~halt_req;
	end
endmodule // platform_ctl

// ---- verif/tb_clock_output_stop_powerdown.sv ----
module tb_clock_output_stop_powerdown
	import clk_stop_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// Arbitrary identification value
	localparam logic [4:0] PART_ID = 5'h15;

	logic core_clk, rst, supply_on, pd_req, halt_req, power_down_n, cpu_halt_n;
	logic se_hiz_strap, ref_clk, ref_clk_oe, vn, vn_oe, vs, vs_oe, pll_enable, xtal_enable;
	cfg_req_type cfg_req;
	logic [7:0] cfg_rdata, a, b;
	logic [1:0] cpu_clk_true, cpu_clk_comp, hs;
	diff_pair_type aux_diff;
	logic [3:0] spread_code, code;
	logic [5:0] oe;
	int fails, total_checks, seed;

	platform_ctl i_platform_ctl (
		.core_clk(core_clk), .supply_on(supply_on), .pd_req(pd_req),
		.halt_req(halt_req), .power_down_n(power_down_n), .cpu_halt_n(cpu_halt_n)
	);

	clock_output_stop_powerdown #(.LOCK_CYC(20), .PART_ID(PART_ID)) i_clock_output_stop_powerdown (
		.core_clk(core_clk), .rst(rst), .power_down_n(power_down_n),
		.cpu_halt_n(cpu_halt_n), .se_hiz_strap(se_hiz_strap), .cfg_req(cfg_req),
		.cfg_rdata(cfg_rdata), .cpu_clk_true(cpu_clk_true), .cpu_clk_comp(cpu_clk_comp),
		.aux_diff(aux_diff), .ref_clk(ref_clk), .ref_clk_oe(ref_clk_oe),
		.video_clk_nonspread(vn), .video_clk_nonspread_oe(vn_oe),
		.video_clk_spread(vs), .video_clk_spread_oe(vs_oe), .spread_code(spread_code),
		.pll_enable(pll_enable), .xtal_enable(xtal_enable)
	);

	always #20 core_clk = ~core_clk;

	task automatic finish_test;
		$display("checks %0d errors %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		@(posedge core_clk);
		cfg_req <= '{1'b1, ad, d};
		@(posedge core_clk);
		cfg_req <= '{1'b0, ad, 8'h00};
	endtask

	task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
		@(posedge core_clk);
		cfg_req <= '{1'b0, ad, 8'h00};
		cyc(1);
		chk("cfg_rdata", cfg_rdata, exp);
	endtask

	function automatic logic [7:0] clk_vec();
		return {2'b00, vs, vn, ref_clk, aux_diff.clk_true, cpu_clk_true};
	endfunction

	// Which outputs toggle: bit order follows the enable byte
	function automatic logic [7:0] exp_run(logic [5:0] en, logic [1:0] stp, logic [3:0] c);
		logic v;
		v = (c >= 4'h2) && (c <= 4'hA);
		return {2'b00, en & {v, v, 2'b11, ~stp}};
	endfunction

	task automatic run_chk(input logic [7:0] exp);
		cyc(1);
		a = clk_vec();
		cyc(1);
		b = clk_vec();
		chk("running", a ^ b, exp);
	endtask

	task automatic pd_cycle(input logic s);
		@(posedge core_clk);
		se_hiz_strap <= s;
		pd_req <= 1'b1;
		cyc(24);
		chk("pd_clk", {cpu_clk_true, cpu_clk_comp, aux_diff, ref_clk, vn}, 8'h00);
		chk("pd_oe", {5'h00, ref_clk_oe, vn_oe, vs_oe}, {5'h00, {3{~s}}});
		chk("pd_osc", {6'h00, pll_enable, xtal_enable}, 8'h00);
		@(posedge core_clk);
		pd_req <= 1'b0;
		cyc(3);
		chk("diff_high", {2'b00, cpu_clk_true, cpu_clk_comp, aux_diff}, 8'h3F);
		cyc(30);
		chk("pll_on", {7'h00, pll_enable}, 8'h01);
		run_chk(exp_run(oe, 2'b00, code));
	endtask

	initial begin
		core_clk = 1'b0;
		rst = 1'b1;
		supply_on = 1'b0;
		pd_req = 1'b0;
		halt_req = 1'b0;
		se_hiz_strap = 1'b0;
		cfg_req = '0;
		seed = 40408;
		oe = 6'h3F;
		code = 4'h0;
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		rd(8'h0E, {3'h5, PART_ID});
		rd(8'h0A, 8'h03);
		rd(8'h02, 8'h3F);
		rd(8'h01, 8'h00);
		wr(8'h0E, 8'hFF);
		rd(8'h0E, {3'h5, PART_ID});
		wr(8'h33, 8'hFF);
		rd(8'h33, 8'h00);
		// Power-down held as initial state
		@(posedge core_clk);
		supply_on <= 1'b1;
		pd_req <= 1'b1;
		cyc(30);
		chk("init_pd", {6'h00, pll_enable, xtal_enable}, 8'h00);
		@(posedge core_clk);
		pd_req <= 1'b0;
		cyc(3);
		chk("diff_high", {2'b00, cpu_clk_true, cpu_clk_comp, aux_diff}, 8'h3F);
		cyc(30);
		run_chk(exp_run(oe, 2'b00, code));
		for (int c = 0; c < 16; c++) begin
			code = c[3:0];
			wr(8'h01, {3'h0, code, 1'b0});
			rd(8'h01, {3'h0, code, 1'b0});
			chk("spread_code", {4'h0, spread_code}, {4'h0, code});
			run_chk(exp_run(oe, 2'b00, code));
		end
		for (int i = 0; i < 8; i++) begin
			oe = (i == 0) ? 6'h3F : 6'($random(seed));
			hs = (i == 1) ? 2'b00 : 2'($random(seed));
			code = 4'($random(seed));
			wr(8'h02, {2'b00, oe});
			wr(8'h0A, {6'h00, hs});
			wr(8'h01, {3'h0, code, 1'b0});
			rd(8'h0A, {6'h00, hs});
			run_chk(exp_run(oe, 2'b00, code));
			@(posedge core_clk);
			halt_req <= 1'b1;
			cyc(16);
			chk("park_t", {6'h00, cpu_clk_true & oe[1:0] & hs}, {6'h00, oe[1:0] & hs});
			chk("park_c", {6'h00, cpu_clk_comp & oe[1:0] & hs}, 8'h00);
			chk("off_diff", {6'h00, (cpu_clk_true | cpu_clk_comp) & ~oe[1:0]}, 8'h00);
			chk("off_se", {5'h00, {vs, vn, ref_clk} & ~oe[5:3]}, 8'h00);
			run_chk(exp_run(oe, hs, code));
			@(posedge core_clk);
			halt_req <= 1'b0;
			cyc(6);
			run_chk(exp_run(oe, 2'b00, code));
		end
		pd_cycle(1'b0);
		pd_cycle(1'b1);
		finish_test();
	end

	initial begin
		#(40 * 20000);
		fails++;
		finish_test();
	end
endmodule // tb_clock_output_stop_powerdown
